// File: hdl/tmr_pkg.sv
// Package of constants and types for the triple timer/event counter block
package tmr_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CNT0_HI = 8'h0C;
  localparam logic [7:0] IDX_CNT0_LO = 8'h0D;
  localparam logic [7:0] IDX_CNT0_CTL = 8'h0E;
  localparam logic [7:0] IDX_CNT1_HI = 8'h0F;
  localparam logic [7:0] IDX_CNT1_LO = 8'h10;
  localparam logic [7:0] IDX_CNT1_CTL = 8'h11;
  localparam logic [7:0] IDX_CNT2_VAL = 8'h2C;
  localparam logic [7:0] IDX_CNT2_CTL = 8'h2D;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h30;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h31;
  localparam logic [7:0] IDX_PFD_CFG = 8'h32;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int CLK_SEL_BIT = 5;
  localparam int RUN_BIT = 4;
  localparam int EDGE_BIT = 3;
  localparam int PSC_HI = 2;
  localparam int PSC_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h08;
  localparam logic [7:0] CTL_WMASK [0:2] = '{8'hDF, 8'hF8, 8'hDF};

  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;

  // FREQ_DIVIDER_OUT configuration register fields
  localparam int PFD_EN_BIT = 0;
  localparam int PFD_SRC_BIT = 1;

  // ----------------------------------------------------------------
  // Counter limits and prescaler
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_MAX [0:2] = '{16'hFFFF, 16'hFFFF, 16'h00FF};
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam int PSC_W = 7;
  localparam logic [PSC_W-1:0] PSC_RESET = 7'h00;
  localparam logic [1:0] DIV4_MASK = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    RID_NONE = 4'h0,
    RID_C0_HI = 4'h1,
    RID_C0_LO = 4'h2,
    RID_C0_CTL = 4'h3,
    RID_C1_HI = 4'h4,
    RID_C1_LO = 4'h5,
    RID_C1_CTL = 4'h6,
    RID_C2_VAL = 4'h7,
    RID_C2_CTL = 4'h8,
    RID_FLAGS = 4'h9,
    RID_ENABLE = 4'hA,
    RID_PFD = 4'hB
  } reg_id_t;

  localparam reg_id_t HI_IDS [0:2] = '{RID_C0_HI, RID_C1_HI, RID_C2_VAL};
  localparam reg_id_t LO_IDS [0:1] = '{RID_C0_LO, RID_C1_LO};
  localparam reg_id_t CTL_IDS [0:2] = '{RID_C0_CTL, RID_C1_CTL, RID_C2_CTL};

endpackage : tmr_pkg

// File: hdl/triple_timer_event_counter.sv
// Three timer/event counters behind an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module triple_timer_event_counter
  import tmr_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Link side
  input wire logic [2:0] event_input_i,
  input wire logic rtc_osc_i,
  output logic freq_divider_out_o,
  output logic [2:0] irq_o,
  output logic wake_o,
  output logic [PSC_W-1:0] pwm_count_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic reg_id_t reg_id(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = 8'(addr[ADDR_W-1:2]);
    unique case (idx)
      IDX_CNT0_HI: reg_id = RID_C0_HI;
      IDX_CNT0_LO: reg_id = RID_C0_LO;
      IDX_CNT0_CTL: reg_id = RID_C0_CTL;
      IDX_CNT1_HI: reg_id = RID_C1_HI;
      IDX_CNT1_LO: reg_id = RID_C1_LO;
      IDX_CNT1_CTL: reg_id = RID_C1_CTL;
      IDX_CNT2_VAL: reg_id = RID_C2_VAL;
      IDX_CNT2_CTL: reg_id = RID_C2_CTL;
      IDX_IRQ_FLAGS: reg_id = RID_FLAGS;
      IDX_IRQ_ENABLE: reg_id = RID_ENABLE;
      IDX_PFD_CFG: reg_id = RID_PFD;
      default: reg_id = RID_NONE;
    endcase
  endfunction : reg_id

  // Tick of a 2**sel divider taken from the shared prescaler
  function automatic logic psc_tick(input logic [PSC_W-1:0] cnt,
                                    input logic [2:0] sel);
    logic [PSC_W:0] span;
    span = (8'h01 << sel) - 8'h01;
    psc_tick = &(cnt | ~span[PSC_W-1:0]);
  endfunction : psc_tick

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  logic aw_have_ff;
  logic w_have_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wlane0_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_wr;
  reg_id_t wid;
  logic nxt_aw_have;
  logic nxt_w_have;

  assign do_wr = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wid = reg_id(awaddr_ff);

  always_comb
  begin
    nxt_aw_have = (aw_have_ff | (s_axi_awvalid_i & awready_ff)) & ~do_wr;
    nxt_w_have = (w_have_ff | (s_axi_wvalid_i & wready_ff)) & ~do_wr;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      awaddr_ff <= '0;
      wbyte_ff <= 8'h00;
      wlane0_ff <= 1'b0;
    end
    else
    begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      awready_ff <= ~nxt_aw_have;
      wready_ff <= ~nxt_w_have;
      if (s_axi_awvalid_i & awready_ff)
        awaddr_ff <= s_axi_awaddr_i;
      if (s_axi_wvalid_i & wready_ff)
      begin
        wbyte_ff <= s_axi_wdata_i[7:0];
        wlane0_ff <= s_axi_wstrb_i[0];
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wid == RID_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready_i)
      bvalid_ff <= 1'b0;
  end

  // Only byte lane 0 carries register data
  logic wr_ok;
  assign wr_ok = do_wr & wlane0_ff;

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  logic arready_ff;
  logic rvalid_ff;
  logic [7:0] rbyte_ff;
  logic [1:0] rresp_ff;
  logic rd_acc;
  reg_id_t rid;
  logic [7:0] rd_mux;

  assign rd_acc = s_axi_arvalid_i & arready_ff;
  assign rid = reg_id(s_axi_araddr_i);

  // ----------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------
  logic [15:0] cnt_ff [0:2];
  logic [15:0] preload_ff [0:2];
  logic [7:0] ctl_ff [0:2];
  logic [7:0] lobuf_ff [0:1];
  logic [2:0] flag_ff;
  logic [2:0] irq_en_ff;
  logic [1:0] pfd_cfg_ff;
  logic [PSC_W-1:0] psc_ff;
  logic [2:0] ev_q_ff;
  logic rtc_q_ff;
  logic [2:0] int_tick;
  logic [2:0] ovf;
  logic [2:0] hw_clr_run;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      psc_ff <= PSC_RESET;
    else
      psc_ff <= psc_ff + 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ev_q_ff <= 3'h0;
      rtc_q_ff <= 1'b0;
    end
    else
    begin
      ev_q_ff <= event_input_i;
      rtc_q_ff <= rtc_osc_i;
    end
  end

  assign int_tick[0] = psc_tick(psc_ff, ctl_ff[0][PSC_HI:PSC_LO]);
  assign int_tick[1] = ctl_ff[1][CLK_SEL_BIT] ? (rtc_osc_i & ~rtc_q_ff)
                       : (&(psc_ff[1:0] | ~DIV4_MASK));
  assign int_tick[2] = psc_tick(psc_ff, ctl_ff[2][PSC_HI:PSC_LO]);

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 3; i++)
  begin : g_cnt
    logic [1:0] mode;
    logic run;
    logic edge_sel;
    logic rise;
    logic fall;
    logic start_edge;
    logic stop_edge;
    logic inc;
    logic rd_blk;
    logic wr_hi;
    logic meas_ff;

    assign mode = ctl_ff[i][MODE_HI:MODE_LO];
    assign run = ctl_ff[i][RUN_BIT];
    assign edge_sel = ctl_ff[i][EDGE_BIT];
    assign rise = event_input_i[i] & ~ev_q_ff[i];
    assign fall = ~event_input_i[i] & ev_q_ff[i];
    assign start_edge = edge_sel ? rise : fall;
    assign stop_edge = edge_sel ? fall : rise;
    // A read of this counter's value registers (high or low byte, not control) holds its clock
    assign rd_blk = rd_acc & ((rid == HI_IDS[i]) ||
                    (i < 2 && rid == LO_IDS[i < 2 ? i : 0]));
    assign wr_hi = wr_ok & (wid == HI_IDS[i]);

    always_comb
    begin
      unique case (mode)
        MODE_EVENT: inc = edge_sel ? fall : rise;
        MODE_TIMER: inc = int_tick[i];
        MODE_PULSE: inc = meas_ff & int_tick[i];
        default: inc = 1'b0;
      endcase
      inc = inc & run & ~rd_blk;
    end

    assign ovf[i] = inc & (cnt_ff[i] == CNT_MAX[i]);
    assign hw_clr_run[i] = run & (mode == MODE_PULSE) & meas_ff
                           & stop_edge;

    // Single shot: the run bit is gone after the stop edge
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
        meas_ff <= 1'b0;
      else if (~run || mode != MODE_PULSE)
        meas_ff <= 1'b0;
      else if (meas_ff & stop_edge)
        meas_ff <= 1'b0;
      else if (~meas_ff & start_edge)
        meas_ff <= 1'b1;
    end

    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
        preload_ff[i] <= CNT_RESET;
      else if (wr_hi)
      begin
        if (i < 2)
          preload_ff[i] <= {wbyte_ff, lobuf_ff[i < 2 ? i : 0]};
        else
          preload_ff[i] <= {8'h00, wbyte_ff};
      end
    end

    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
        cnt_ff[i] <= CNT_RESET;
      else if (wr_hi & ~run)
      begin
        if (i < 2)
          cnt_ff[i] <= {wbyte_ff, lobuf_ff[i < 2 ? i : 0]};
        else
          cnt_ff[i] <= {8'h00, wbyte_ff};
      end
      else if (ovf[i])
        cnt_ff[i] <= preload_ff[i];
      else if (inc)
        cnt_ff[i] <= cnt_ff[i] + 16'h0001;
    end

    // Software write wins over the automatic clear of the run bit
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
        ctl_ff[i] <= CTL_RESET;
      else if (wr_ok & (wid == CTL_IDS[i]))
        ctl_ff[i] <= wbyte_ff & CTL_WMASK[i];
      else if (hw_clr_run[i])
        ctl_ff[i][RUN_BIT] <= 1'b0;
    end

    if (i < 2)
    begin : g_lobuf
      always_ff @(posedge core_clk_i)
      begin
        if (rst_i)
          lobuf_ff[i] <= 8'h00;
        else if (rd_acc & (rid == HI_IDS[i]))
          lobuf_ff[i] <= cnt_ff[i][7:0];
        else if (wr_ok & (wid == LO_IDS[i]))
          lobuf_ff[i] <= wbyte_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, interrupt, wake-up and divider output
  // ----------------------------------------------------------------
  // Flags clear by writing one; an overflow in that cycle keeps the flag
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      flag_ff <= 3'h0;
    else if (wr_ok & (wid == RID_FLAGS))
      flag_ff <= (flag_ff & ~wbyte_ff[2:0]) | ovf;
    else
      flag_ff <= flag_ff | ovf;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      irq_en_ff <= 3'h0;
      pfd_cfg_ff <= 2'h0;
    end
    else
    begin
      if (wr_ok & (wid == RID_ENABLE))
        irq_en_ff <= wbyte_ff[2:0];
      if (wr_ok & (wid == RID_PFD))
        pfd_cfg_ff <= wbyte_ff[1:0];
    end
  end

  logic [2:0] irq_ff;
  logic wake_ff;
  logic pfd_ff;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      irq_ff <= 3'h0;
      wake_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= flag_ff & irq_en_ff;
      wake_ff <= |ovf;
    end
  end

  // Held low while disabled, so it restarts from a known phase
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      pfd_ff <= 1'b0;
    else if (~pfd_cfg_ff[PFD_EN_BIT])
      pfd_ff <= 1'b0;
    else if (ovf[pfd_cfg_ff[PFD_SRC_BIT] ? 1 : 0])
      pfd_ff <= ~pfd_ff;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (rid)
      RID_C0_HI: rd_mux = cnt_ff[0][15:8];
      RID_C0_LO: rd_mux = lobuf_ff[0];
      RID_C0_CTL: rd_mux = ctl_ff[0];
      RID_C1_HI: rd_mux = cnt_ff[1][15:8];
      RID_C1_LO: rd_mux = lobuf_ff[1];
      RID_C1_CTL: rd_mux = ctl_ff[1];
      RID_C2_VAL: rd_mux = cnt_ff[2][7:0];
      RID_C2_CTL: rd_mux = ctl_ff[2];
      RID_FLAGS: rd_mux = {5'h00, flag_ff};
      RID_ENABLE: rd_mux = {5'h00, irq_en_ff};
      RID_PFD: rd_mux = {6'h00, pfd_cfg_ff};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rbyte_ff <= 8'h00;
      rresp_ff <= RESP_OKAY;
    end
    else if (rd_acc)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rbyte_ff <= rd_mux;
      rresp_ff <= (rid == RID_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid_ff)
    begin
      if (s_axi_rready_i)
      begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
    else
      arready_ff <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign s_axi_rdata_o = {24'h000000, rbyte_ff};
  assign freq_divider_out_o = pfd_ff;
  assign irq_o = irq_ff;
  assign wake_o = wake_ff;
  assign pwm_count_o = psc_ff;

endmodule : triple_timer_event_counter

`default_nettype wire

// File: testbench/ttec_asserts.sv
// Checker of the bus handshakes and link outputs of the timer block
`timescale 1ns/1ps
`default_nettype none
module ttec_asserts
  import tmr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic freq_divider_out_o,
  input wire logic wake_o,
  input wire logic [PSC_W-1:0] pwm_count_o
);
  // ---
  // Properties
  // ---
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp lost");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata lost");
  wr_latency_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write answer late");
  rd_latency_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o) else $error("read answer late");
  aw_block_a: assert property (s_axi_awvalid_i && s_axi_awready_o
    |=> !s_axi_awready_o) else $error("awready kept high");
  ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("arready during read answer");
  rdata_zero_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 0)
    else $error("upper read bits set");
  bresp_code_a: assert property (s_axi_bvalid_o |->
    s_axi_bresp_o == RESP_OKAY || s_axi_bresp_o == RESP_SLVERR)
    else $error("bad write response");
  divider_toggle_a: assert property (
    $changed(freq_divider_out_o) |-> wake_o || $past(wake_o) ||
    !freq_divider_out_o) else $error("divider moved without overflow");
  pwm_run_a: assert property (
    !$past(rst_i) |-> pwm_count_o == $past(pwm_count_o) + 7'h01)
    else $error("prescaler count not free running");
endmodule : ttec_asserts
bind triple_timer_event_counter ttec_asserts i_chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i),
  .freq_divider_out_o(freq_divider_out_o),
  .wake_o(wake_o),
  .pwm_count_o(pwm_count_o)
);
`default_nettype wire

// File: testbench/ttec_pin_src.sv
// Model of the event pin sources and the slow oscillator
`timescale 1ns/1ps
`default_nettype none
module ttec_pin_src
#(
  parameter int RTC_HALF = 3815
)
(
  input wire logic core_clk_i,
  output logic [2:0] event_o,
  output logic rtc_o
);
  int n = 0;
  initial
  begin
    event_o = 3'h0;
    rtc_o = 1'b0;
  end
  // ---
  // Crystal runs free, far slower than the core clock
  // ---
  always @(posedge core_clk_i)
  begin
    n <= (n == RTC_HALF - 1) ? 0 : n + 1;
    if (n == RTC_HALF - 1)
      rtc_o <= ~rtc_o;
  end
  task automatic lvl(input int ch, input logic v);
    @(posedge core_clk_i);
    event_o[ch] <= v;
  endtask : lvl
endmodule : ttec_pin_src
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the triple timer/event counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tmr_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, rtc, fdo;
  logic awready, wready, bvalid, arready, rvalid, wake;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [2:0] ev, irq;
  logic [6:0] pwm;
  logic fdo_q;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int tog = 0;
  int wk = 0;
  logic [7:0] hi_i [3] = '{IDX_CNT0_HI, IDX_CNT1_HI, IDX_CNT2_VAL};
  logic [7:0] lo_i [3] = '{IDX_CNT0_LO, IDX_CNT1_LO, IDX_CNT2_VAL};
  logic [7:0] ct_i [3] = '{IDX_CNT0_CTL, IDX_CNT1_CTL, IDX_CNT2_CTL};
  triple_timer_event_counter i_dut (.core_clk_i(clk), .rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .event_input_i(ev),
    .rtc_osc_i(rtc), .freq_divider_out_o(fdo), .irq_o(irq), .wake_o(wake),
    .pwm_count_o(pwm));
  ttec_pin_src i_src (.core_clk_i(clk), .event_o(ev), .rtc_o(rtc));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    fdo_q <= fdo;
    if (fdo !== fdo_q)
      tog <= tog + 1;
    if (wake === 1'b1)
      wk <= wk + 1;
  end
  // ---
  // Bus and compare tasks
  // ---
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input int lo, input int hi,
    input logic [31:0] g);
    check_count++;
    if ($isunknown(g) || g < lo || g > hi)
    begin
      n_fail++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
    input logic [1:0] er = RESP_OKAY);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    @(posedge clk);
    awaddr <= {idx[5:0], 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (a || w)
    begin
      @(posedge clk);
      if (a && awready === 1'b1)
      begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
    input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    araddr <= {idx[5:0], 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd
  task automatic rc(input string nm, input logic [7:0] idx,
    input logic [7:0] e);
    logic [31:0] v;
    rd(idx, v);
    chk(nm, {24'h0, e}, v);
  endtask : rc
  task automatic ld(input int c, input logic [15:0] v);
    if (c != 2)
      wr(lo_i[c], v[7:0]);
    wr(hi_i[c], c == 2 ? v[7:0] : v[15:8]);
  endtask : ld
  task automatic get(input int c, output logic [31:0] v);
    logic [31:0] h, l;
    rd(hi_i[c], h);
    l = h;
    if (c != 2)
      rd(lo_i[c], l);
    v = (c == 2) ? h : {16'h0, h[7:0], l[7:0]};
  endtask : get
  task automatic run(input int c, input logic [7:0] ct, input int n,
    input int dv);
    int t0, d;
    logic [31:0] v;
    ld(c, 16'h0);
    wr(ct_i[c], ct);
    wr(ct_i[c], ct | 8'h10);
    t0 = cyc;
    repeat (n) @(posedge clk);
    wr(ct_i[c], ct);
    d = cyc - t0;
    get(c, v);
    chk_rng("count", d / dv - 1, d / dv + 1, v);
  endtask : run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("[ERR] watchdog expected end seen hang");
    end_of_test();
  end
  initial
  begin
    logic [31:0] v, w;
    int t0, w0;
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int c = 0; c < 3; c++)
      rc("ctl reset", ct_i[c], CTL_RESET);
    rd(8'h3F, v, RESP_SLVERR);
    chk("unmapped", 32'h0, v);
    wr(8'h3F, 8'hFF, RESP_SLVERR);
    ld(0, 16'h1234);
    rc("hi", IDX_CNT0_HI, 8'h12);
    rc("lo", IDX_CNT0_LO, 8'h34);
    wr(IDX_CNT2_VAL, 8'h5A);
    rc("c2", IDX_CNT2_VAL, 8'h5A);
    $display("test registers done");
    for (int e = 0; e < 2; e++)
    begin
      wr(IDX_CNT0_CTL, {4'h4, e[0], 3'h0});
      ld(0, 16'hFFFE);
      wr(IDX_CNT0_CTL, {4'h5, e[0], 3'h0});
      ld(0, 16'h00AA);
      i_src.lvl(0, 1'b1);
      repeat (4) @(posedge clk);
      get(0, v);
      chk("rise", e ? 32'hFFFE : 32'hFFFF, v);
      i_src.lvl(0, 1'b0);
      repeat (4) @(posedge clk);
      get(0, v);
      chk("fall", 32'hFFFF, v);
      i_src.lvl(0, 1'b1);
      i_src.lvl(0, 1'b0);
      repeat (4) @(posedge clk);
      get(0, v);
      chk("reload", 32'h00AA, v);
      rc("flag", IDX_IRQ_FLAGS, 8'h01);
      wr(IDX_IRQ_ENABLE, {7'h0, ~e[0]});
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, ~e[0]}, {29'h0, irq});
      wr(IDX_CNT0_CTL, 8'h40);
      wr(IDX_IRQ_FLAGS, 8'h07);
    end
    $display("test events done");
    for (int k = 0; k < 8; k++)
    begin
      run(0, {5'h10, k[2:0]}, 200, 1 << k);
      run(2, {5'h10, k[2:0]}, 200, 1 << k);
    end
    run(1, 8'h80, 200, 4);
    run(1, 8'hA0, 16000, 7629);
    $display("test timers done");
    for (int e = 0; e < 2; e++)
    begin
      i_src.lvl(2, ~e[0]);
      ld(2, 16'h0);
      wr(IDX_CNT2_CTL, {4'hC, e[0], 3'h0});
      wr(IDX_CNT2_CTL, {4'hD, e[0], 3'h0});
      i_src.lvl(2, e[0]);
      repeat (40) @(posedge clk);
      i_src.lvl(2, ~e[0]);
      repeat (4) @(posedge clk);
      rc("run clear", IDX_CNT2_CTL, {4'hC, e[0], 3'h0});
      rd(IDX_CNT2_VAL, v);
      chk_rng("width", 40, 42, v);
      i_src.lvl(2, e[0]);
      repeat (9) @(posedge clk);
      i_src.lvl(2, ~e[0]);
      repeat (4) @(posedge clk);
      rd(IDX_CNT2_VAL, w);
      chk("one shot", v, w);
    end
    $display("test pulse done");
    ld(0, 16'hFFFE);
    wr(IDX_CNT0_CTL, 8'h80);
    wr(IDX_PFD_CFG, 8'h01);
    wr(IDX_CNT0_CTL, 8'h90);
    t0 = tog;
    w0 = wk;
    repeat (40) @(posedge clk);
    chk_rng("divider", 19, 21, tog - t0);
    chk_rng("wake", 19, 21, wk - w0);
    rc("run kept", IDX_CNT0_CTL, 8'h90);
    wr(IDX_PFD_CFG, 8'h03);
    repeat (4) @(posedge clk);
    t0 = tog;
    repeat (40) @(posedge clk);
    chk("divider src", 32'h0, tog - t0);
    wr(IDX_PFD_CFG, 8'h00);
    repeat (4) @(posedge clk);
    chk("divider off", 32'h0, {31'h0, fdo});
    $display("test divider done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
